// ---- src/retr_pkg.sv ----
/*
 * Package for the rail enable and trim register block: offsets, field
 * positions, reset values and the mode enumeration.
 * Assumes an external serial front end that presents byte-wide register
 * reads and writes on the sys_clk domain.
 */
package retr_pkg;

   // ******************************
   // Register offsets
   // ******************************
   localparam logic [7:0] RETR_OFS_ENABLE = 8'h01;
   localparam logic [7:0] RETR_OFS_PTRIM  = 8'h02;

   // ******************************
   // Enable register fields
   // ******************************
   localparam int RETR_BIT_UP_REQ   = 7;
   localparam int RETR_BIT_DN_REQ   = 6;
   localparam int RETR_BIT_SW_ON    = 5;
   localparam int RETR_BIT_BIAS_ON  = 4;
   localparam int RETR_BIT_GATEP_ON = 3;
   localparam int RETR_BIT_SRCP_ON  = 2;
   localparam int RETR_BIT_GATEN_ON = 1;
   localparam int RETR_BIT_SRCN_ON  = 0;
   localparam logic [7:0] RETR_ENABLE_RST = 8'h1F;

   // ******************************
   // Positive trim register fields
   // ******************************
   localparam int RETR_GTRIM_LSB = 4;
   localparam int RETR_OFFS_LSB  = 0;
   localparam logic [2:0] RETR_GTRIM_RST = 3'h2;
   localparam logic [2:0] RETR_OFFS_RST  = 3'h3;
   localparam logic [2:0] RETR_GTRIM_MAX = 3'h4;
   localparam logic [2:0] RETR_OFFS_RSVD = 3'h7;

   // Rail count: bias, gate pos, source pos, gate neg, source neg
   localparam int RETR_NRAILS = 5;

   typedef enum logic [1:0] {
      RETR_STANDBY,
      RETR_RAMP_UP,
      RETR_ACTIVE,
      RETR_RAMP_DOWN
   } retr_mode_t;

endpackage

// ---- src/retr_regs.sv ----
/*
 * Enable and positive trim registers with mode request handling and rail
 * enable gating.
 * Assumes a serial front end issuing one-cycle byte writes/reads on sys_clk,
 * an external sequencer that reports ramp completion, and asynchronous
 * rail enable pins.
 */
`timescale 1ns/1ps

// Functional notes
// - Writing power-up request starts rail ramp up
// - Writing power-down request starts rail ramp down
// - Request bits self-clear after transition completes
// - Power-down request wins over power-up
// - Bit 5 drives supply switch, resets 0
// - Five rail enables at bits 4..0, reset 1
// - Positive source off until negative enabled
// - Negative source off forces positive off
// - Rail on needs register bit AND pin
// - Gate pump trim bits 6:4, reset 010
// - Positive source level tracks negative level
// - Ramp down uses reverse power-up order
// - Pin falling edge when up disables rail
module retr_regs
   import retr_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   output      logic [7:0]             reg_rdata,
   output      logic                   reg_ack,
   input  wire logic [RETR_NRAILS-1:0] rail_enable_pins,
   input  wire logic                   seq_done,
   input  wire logic [2:0]             neg_source_level,
   output      logic                   seq_up_start,
   output      logic                   seq_down_start,
   output      logic                   seq_reverse,
   output      logic                   active_mode,
   output      logic                   aux_supply_switch_on,
   output      logic                   backplane_bias_buffer_on,
   output      logic                   pos_gate_pump_on,
   output      logic                   pos_source_ldo_on,
   output      logic                   neg_gate_pump_on,
   output      logic                   neg_source_ldo_on,
   output      logic [2:0]             pos_gate_pump_trim,
   output      logic [2:0]             pos_source_offset,
   output      logic [2:0]             pos_source_level
);

   // ******************************
   // State
   // ******************************
   logic [7:0]             enable_r;
   logic [2:0]             gtrim_r;
   logic [2:0]             offs_r;
   retr_mode_t             mode_r;
   logic [RETR_NRAILS-1:0] pin_s1_r;
   logic [RETR_NRAILS-1:0] pin_s2_r;
   logic [RETR_NRAILS-1:0] pin_d_r;
   logic [RETR_NRAILS-1:0] pin_kill_r;
   logic [RETR_NRAILS-1:0] pin_fall;
   logic [RETR_NRAILS-1:0] rail_req;
   logic                   wr_en;
   logic                   wr_tr;
   logic                   up_go;
   logic                   dn_go;
   logic                   srcn_eff;

   assign wr_en = reg_wr && (reg_addr == RETR_OFS_ENABLE);
   assign wr_tr = reg_wr && (reg_addr == RETR_OFS_PTRIM);

   // ******************************
   // Pin synchroniser and edge detect
   // ******************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_d_r  <= '0;
      end else begin
         pin_s1_r <= rail_enable_pins;
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
      end
   end

   assign pin_fall = pin_d_r & ~pin_s2_r;

   // Falling edge latches rail off while active; latch cleared on ramp up start and during ramp up
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_kill_r <= '0;
      end else if (mode_r == RETR_RAMP_UP || up_go) begin
         pin_kill_r <= '0;
      end else if (mode_r == RETR_ACTIVE) begin
         pin_kill_r <= pin_kill_r | pin_fall;
      end
   end

   // ******************************
   // Mode requests
   // ******************************
   assign dn_go = enable_r[RETR_BIT_DN_REQ] && mode_r == RETR_ACTIVE;
   assign up_go = enable_r[RETR_BIT_UP_REQ] && !enable_r[RETR_BIT_DN_REQ]
                  && mode_r == RETR_STANDBY;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_r <= RETR_STANDBY;
      end else begin
         unique case (mode_r)
            RETR_STANDBY:   if (up_go) mode_r <= RETR_RAMP_UP;
            RETR_RAMP_UP:   if (seq_done) mode_r <= RETR_ACTIVE;
            RETR_ACTIVE:    if (dn_go) mode_r <= RETR_RAMP_DOWN;
            RETR_RAMP_DOWN: if (seq_done) mode_r <= RETR_STANDBY;
         endcase
      end
   end

   assign seq_up_start   = up_go;
   assign seq_down_start = dn_go;
   assign seq_reverse    = (mode_r == RETR_RAMP_DOWN);
   assign active_mode    = (mode_r == RETR_ACTIVE);

   // ******************************
   // Enable register
   // ******************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         enable_r <= RETR_ENABLE_RST;
      end else begin
         if (wr_en) begin
            enable_r[5:0] <= reg_wdata[5:0];
         end
         // Request bits: write sets; completion clears, a new write wins
         if (wr_en && reg_wdata[RETR_BIT_UP_REQ]) begin
            enable_r[RETR_BIT_UP_REQ] <= 1'b1;
         end else if ((mode_r == RETR_RAMP_UP && seq_done) ||
                      (enable_r[RETR_BIT_UP_REQ] && mode_r == RETR_ACTIVE)) begin
            enable_r[RETR_BIT_UP_REQ] <= 1'b0;
         end else if (enable_r[RETR_BIT_DN_REQ] && enable_r[RETR_BIT_UP_REQ]) begin
            enable_r[RETR_BIT_UP_REQ] <= 1'b0;
         end
         if (wr_en && reg_wdata[RETR_BIT_DN_REQ]) begin
            enable_r[RETR_BIT_DN_REQ] <= 1'b1;
         end else if ((mode_r == RETR_RAMP_DOWN && seq_done) ||
                      (enable_r[RETR_BIT_DN_REQ] && mode_r == RETR_STANDBY)) begin
            enable_r[RETR_BIT_DN_REQ] <= 1'b0;
         end
      end
   end

   // ******************************
   // Trim register
   // ******************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gtrim_r <= RETR_GTRIM_RST;
         offs_r  <= RETR_OFFS_RST;
      end else if (wr_tr) begin
         gtrim_r <= reg_wdata[RETR_GTRIM_LSB +: 3];
         offs_r  <= reg_wdata[RETR_OFFS_LSB +: 3];
      end
   end

   // ******************************
   // Read path
   // ******************************
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
         reg_ack   <= 1'b0;
      end else begin
         reg_ack <= reg_rd || reg_wr;
         if (reg_rd) begin
            unique case (reg_addr)
               RETR_OFS_ENABLE: reg_rdata <= enable_r;
               RETR_OFS_PTRIM:  reg_rdata <= {1'b0, gtrim_r, 1'b0, offs_r};
               default:         reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ******************************
   // Rail outputs
   // ******************************
   assign rail_req = enable_r[4:0] & pin_s2_r & ~pin_kill_r;
   assign srcn_eff = rail_req[RETR_BIT_SRCN_ON];

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         aux_supply_switch_on     <= 1'b0;
         backplane_bias_buffer_on <= 1'b0;
         pos_gate_pump_on         <= 1'b0;
         pos_source_ldo_on        <= 1'b0;
         neg_gate_pump_on         <= 1'b0;
         neg_source_ldo_on        <= 1'b0;
         pos_gate_pump_trim       <= RETR_GTRIM_RST;
         pos_source_offset        <= RETR_OFFS_RST;
         pos_source_level         <= 3'h3;
      end else begin
         aux_supply_switch_on     <= enable_r[RETR_BIT_SW_ON];
         backplane_bias_buffer_on <= rail_req[RETR_BIT_BIAS_ON];
         pos_gate_pump_on         <= rail_req[RETR_BIT_GATEP_ON];
         neg_gate_pump_on         <= rail_req[RETR_BIT_GATEN_ON];
         neg_source_ldo_on        <= srcn_eff;
         // Positive source only with negative source running
         pos_source_ldo_on        <= rail_req[RETR_BIT_SRCP_ON] && srcn_eff
                                     && neg_source_ldo_on;
         pos_gate_pump_trim       <= gtrim_r;
         pos_source_offset        <= offs_r;
         pos_source_level         <= neg_source_level;
      end
   end

endmodule

// ---- bench/retr_seq_model.sv ----
/*
 * Ramp sequencer model answering mode requests with a done pulse.
 * Assumes ramp_cycles is 1 or more and held while a ramp runs.
 */
`timescale 1ns/1ps
module retr_seq_model (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       seq_up_start,
   input  wire logic       seq_down_start,
   input  wire logic [4:0] ramp_cycles,
   output      logic       seq_done
);
   logic [4:0] cnt_r;
   always_ff @(posedge sys_clk) begin
      if (srst) cnt_r <= 5'h00;
      else if (seq_up_start || seq_down_start) cnt_r <= ramp_cycles;
      else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
   end
   assign seq_done = (cnt_r == 5'h01);
endmodule

// ---- bench/retr_regs_monitor.sv ----
/*
 * Checker for rail gating, mode ramps and level tracking.
 * Assumes it is bound to retr_regs.
 */
`timescale 1ns/1ps
module retr_regs_monitor (
   input wire logic       sys_clk,
   input wire logic       srst,
   input wire logic [4:0] rail_enable_pins,
   input wire logic [2:0] neg_source_level,
   input wire logic       seq_done,
   input wire logic       seq_up_start,
   input wire logic       seq_down_start,
   input wire logic       seq_reverse,
   input wire logic       active_mode,
   input wire logic       backplane_bias_buffer_on,
   input wire logic       pos_source_ldo_on,
   input wire logic       neg_source_ldo_on,
   input wire logic [2:0] pos_source_level
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   srcp_after_srcn_a: assert property (pos_source_ldo_on |-> $past(neg_source_ldo_on))
      else $error("pos source on before neg");
   srcn_kills_srcp_a: assert property (!neg_source_ldo_on |=> !pos_source_ldo_on)
      else $error("pos source left on");
   bias_gated_a: assert property (backplane_bias_buffer_on |-> $past(rail_enable_pins[4], 3))
      else $error("bias on without pin");
   up_start_a: assert property (seq_up_start |-> !active_mode && !seq_reverse && !seq_down_start)
      else $error("bad ramp up start");
   down_start_a: assert property (seq_down_start |-> active_mode ##1 seq_reverse)
      else $error("bad ramp down start");
   ramp_hold_a: assert property (seq_reverse && !seq_done |=> seq_reverse)
      else $error("ramp down dropped");
   down_done_a: assert property (seq_reverse && seq_done |=> !active_mode && !seq_reverse)
      else $error("standby not reached");
   level_track_a: assert property (!$past(srst) |-> pos_source_level == $past(neg_source_level))
      else $error("level not tracking");
   up_done_a: assert property (!active_mode && !seq_reverse && seq_done |=> active_mode)
      else $error("active not reached");
   active_hold_a: assert property (active_mode && !seq_down_start |=> active_mode)
      else $error("active mode dropped");
endmodule
bind retr_regs retr_regs_monitor mon_u (.sys_clk, .srst, .rail_enable_pins, .neg_source_level, .seq_done,
   .seq_up_start, .seq_down_start, .seq_reverse, .active_mode, .backplane_bias_buffer_on,
   .pos_source_ldo_on, .neg_source_ldo_on, .pos_source_level);

// ---- bench/testbench.sv ----
/*
 * Self-checking bench for the rail enable and trim registers.
 * Assumes retr_regs and the sequencer model.
 */
`timescale 1ns/1ps
module testbench;
   import retr_pkg::*;
   logic sys_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, seq_done, reg_ack, aux_supply_switch_on;
   logic seq_up_start, seq_down_start, seq_reverse, active_mode, backplane_bias_buffer_on;
   logic pos_gate_pump_on, pos_source_ldo_on, neg_gate_pump_on, neg_source_ldo_on;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
   logic [4:0] rail_enable_pins = 5'h1F, ramp_cycles = 5'h01;
   logic [2:0] neg_source_level = 3'h3, pos_gate_pump_trim, pos_source_offset, pos_source_level;
   int failures = 0, num_checks = 0;
   wire [5:0] outs = {aux_supply_switch_on, backplane_bias_buffer_on, pos_gate_pump_on, pos_source_ldo_on,
                      neg_gate_pump_on, neg_source_ldo_on};
   always #4 sys_clk = ~sys_clk;
   retr_regs dut_u (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
      .rail_enable_pins, .seq_done, .neg_source_level, .seq_up_start, .seq_down_start, .seq_reverse,
      .active_mode, .aux_supply_switch_on, .backplane_bias_buffer_on, .pos_gate_pump_on,
      .pos_source_ldo_on, .neg_gate_pump_on, .neg_source_ldo_on, .pos_gate_pump_trim,
      .pos_source_offset, .pos_source_level);
   retr_seq_model seq_u (.sys_clk, .srst, .seq_up_start, .seq_down_start, .ramp_cycles, .seq_done);
   function automatic logic [4:0] rails(input logic [4:0] b, input logic [4:0] p);
      logic [4:0] e;
      e = b & p;
      e[2] = e[2] & e[0];
      return e;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      chk({7'h00, reg_ack}, 8'h01);
      reg_wr = 1'h0;
      reg_rd = 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'h0, a, 8'h00);
      chk(reg_rdata, exp);
   endtask
   task automatic results;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge sys_clk);
      failures++;
      results();
   end
   initial begin
      v = $urandom(38);
      repeat (3) @(negedge sys_clk);
      srst = 1'h0;
      rd(8'h01, 8'h1F);
      rd(8'h02, 8'h23);
      rd(8'h05, 8'h00);
      acc(1'h1, 8'h02, 8'hCB);
      rd(8'h02, 8'h43);
      for (int i = 0; i < 5; i++) begin
         acc(1'h1, 8'h02, {1'h0, i[2:0], 4'h3});
         @(negedge sys_clk);
         chk({5'h00, pos_gate_pump_trim}, {5'h00, i[2:0]});
         chk({5'h00, pos_source_offset}, 8'h03);
      end
      $display("trim test done");
      for (int i = 0; i < 24; i++) begin
         v = i ? {2'h0, 6'($urandom)} : 8'h3E;
         rail_enable_pins = i ? 5'($urandom) : 5'h1F;
         neg_source_level = 3'($urandom);
         acc(1'h1, 8'h01, v);
         repeat (6) @(negedge sys_clk);
         chk({2'h0, outs}, {2'h0, v[5], rails(v[4:0], rail_enable_pins)});
         chk({5'h00, pos_source_level}, {5'h00, neg_source_level});
         rd(8'h01, v);
      end
      $display("rail test done");
      rail_enable_pins = 5'h1F;
      acc(1'h1, 8'h01, 8'h9F);
      repeat (4) @(negedge sys_clk);
      chk({7'h00, active_mode}, 8'h01);
      rd(8'h01, 8'h1F);
      rail_enable_pins = 5'h0F;
      repeat (4) @(negedge sys_clk);
      rail_enable_pins = 5'h1F;
      repeat (6) @(negedge sys_clk);
      chk({2'h0, outs}, 8'h0F);
      ramp_cycles = 5'h14;
      acc(1'h1, 8'h01, 8'hDF);
      @(negedge sys_clk);
      chk({6'h00, seq_reverse, active_mode}, 8'h02);
      repeat (24) @(negedge sys_clk);
      chk({6'h00, seq_reverse, active_mode}, 8'h00);
      rd(8'h01, 8'h1F);
      $display("mode test done");
      acc(1'h1, 8'h01, 8'h20);
      acc(1'h1, 8'h02, 8'h43);
      repeat (4) @(negedge sys_clk);
      chk({2'h0, outs}, 8'h20);
      srst = 1'h1;
      repeat (3) @(negedge sys_clk);
      chk({2'h0, outs}, 8'h00);
      srst = 1'h0;
      rd(8'h01, 8'h1F);
      rd(8'h02, 8'h23);
      $display("reset test done");
      results();
   end
endmodule
